/* File: rtl/bcs_pkg.sv */
// What this block does
// R01: Reference equals target code times 50mV.
// R02: Over-voltage check stays active, even during ramps.
// R03: Over-voltage shuts channel and sets its flag in the same cycle.
// R04: Trip offset 150-300mV, doubled above 2.5V.
// R05: Over-voltage also disables every mapped follower channel.
// R06: Channels held by over-voltage stay off until host re-enables.
// R07: Any fault or warning routable to GPIO.
// R08: Per-channel passive or forced-low shutdown style.
// R09: Each current sample compared to limit and warning; the limit trips only in switching states.
// R10: Limit bits [5:0] in 5mV steps, to 315mV.
// R11: Warning sits 10, 20, 30 or 40mV below.
// R12: Warning follows current, clears itself when below.
// R13: Over-current stops drive, restarts after 200ms.
// R14: Over-current restarts followers and sets fault flag.
// R15: Start delay is bits [15:10] times 250us.
// R16: Ramp up 50mV every bits [9:0] microseconds.
// R17: Stop delay, then ramp down to discharge.
// R18: Power-good high inside 20mV-step window.
// R19: Power-good and its delay wait for soft-start.
// R20: Rate select: oscillator [6:4], divider [2:0].
// R21: Oscillator codes give 48MHz down to 25.6MHz.
// R22: Divider 000 invalid; rates osc/32, /48, ...
// R23: Warning offset codes ascend from 10mV.
// R24: Delays count microseconds of the selected oscillator.
package bcs_pkg;
  localparam int NCH = 32'h0000_0004;
  // Core clock at 200 MHz, expressed in 100 kHz units for the oscillator model.
  localparam int CORE_CLK_MHZ = 32'h0000_00c8;
  localparam logic [11:0] CORE_100K = 12'(CORE_CLK_MHZ * 32'h0000_000a);
  localparam logic [8:0] US_TICK_STEP = 9'h00a;
  localparam logic [8:0] OSC_TOP_100K = 9'h1e0;
  localparam int DIV_STEP = 32'h0000_0010;
  localparam int MIN_RATE_100K = 32'h0000_0003;
  // Voltage scaling.
  localparam int VOLT_STEP_MV = 32'h0000_0032;
  localparam int MEAS_UNIT_MV = 32'h0000_000a;
  localparam int TARGET_CODE_SCALE = VOLT_STEP_MV / MEAS_UNIT_MV;
  localparam logic [6:0] TARGET_HIGH_CODE = 7'h32;
  localparam int OV_MIN_MV = 32'h0000_0096;
  localparam int OV_STEP_MV = 32'h0000_0032;
  localparam int PG_STEP_MV = 32'h0000_0014;
  localparam logic [6:0] DISCHARGE_CODE = 7'h00;
  // Current scaling.
  localparam int LIM_STEP_MV = 32'h0000_0005;
  localparam int WARN_MIN_MV = 32'h0000_000a;
  localparam int WARN_STEP_MV = 32'h0000_000a;
  // Timing.
  localparam int DELAY_STEP_US = 32'h0000_00fa;
  localparam int OC_RESTART_MS = 32'h0000_00c8;
  localparam int US_PER_MS = 32'h0000_03e8;
  // Register map: per-channel words at {0, ch[1:0], word[2:0], 00}.
  localparam logic [2:0] W_TARGET = 3'h0;
  localparam logic [2:0] W_CURLIM = 3'h1;
  localparam logic [2:0] W_RAMPUP = 3'h2;
  localparam logic [2:0] W_RAMPDN = 3'h3;
  localparam logic [2:0] W_PGWIN = 3'h4;
  localparam logic [2:0] W_PGDLY = 3'h5;
  localparam logic [2:0] W_CHSTAT = 3'h6;
  localparam logic [7:0] A_CHEN = 8'h80;
  localparam logic [7:0] A_FOLLOW_LO = 8'h84;
  localparam logic [7:0] A_FOLLOW_HI = 8'h88;
  localparam logic [7:0] A_SWRATE = 8'h8c;
  localparam logic [7:0] A_PROT = 8'h90;
  localparam logic [7:0] A_OCFAULT = 8'h94;
  localparam logic [7:0] A_OCWARN = 8'h98;
  localparam logic [7:0] A_ROUTE = 8'h9c;
  // Field positions.
  localparam int FLD_OVSEL = 32'h0000_0008;
  localparam int FLD_STYLE = 32'h0000_000c;
  localparam int FLD_STATE = 32'h0000_0007;
  localparam int FLD_PG = 32'h0000_000a;
  localparam int FLD_PGHI = 32'h0000_0008;
  // Values after reset.
  localparam logic [7:0] RST_CURLIM = 8'h3f;
  localparam logic [7:0] RST_SWRATE = 8'h01;
  localparam logic [15:0] RST_RAMP = 16'h0414;

  typedef enum logic [2:0] {
    CH_OFF, CH_DLYUP, CH_RAMPUP, CH_ON, CH_DLYDN, CH_RAMPDN, CH_OVHOLD, CH_OCWAIT
  } bcs_chst_t;

  // Oscillator frequency in 100 kHz units, 3.2 MHz lower per code step.
  function automatic logic [8:0] oscFreq100k(input logic [2:0] sel);
    return OSC_TOP_100K - {1'b0, sel, 5'h00};
  endfunction : oscFreq100k
endpackage : bcs_pkg

/* File: rtl/bcs_timebase.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_timebase
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Rate selection.
  input wire logic [2:0] oscSel,
  input wire logic [2:0] divSel,
  // Enable pulses and status.
  output logic usTick,
  output logic pwmTick,
  output logic rateValid
);
  typedef struct packed {
    logic [11:0] acc;
    logic [8:0] usAcc;
    logic [7:0] divCnt;
    logic osc;
    logic us;
    logic pwm;
    logic valid;
  } bcs_tb_state_t;

  bcs_tb_state_t s_ff, nxt_s;

  always_comb
  begin
    logic [8:0] f;
    logic [11:0] sum;
    logic [8:0] usSum;
    logic [7:0] period;
    f = bcs_pkg::oscFreq100k(oscSel); // [R21]
    sum = s_ff.acc + {3'h0, f};
    usSum = s_ff.usAcc + bcs_pkg::US_TICK_STEP;
    period = {1'b0, divSel, 4'h0} + 8'h0f; // [R22]
    nxt_s = s_ff;
    nxt_s.osc = 1'b0;
    nxt_s.us = 1'b0;
    nxt_s.pwm = 1'b0;
    // Oscillator edges are modelled by a phase accumulator, so ticks jitter by one core cycle.
    if (sum >= bcs_pkg::CORE_100K)
    begin
      nxt_s.acc = sum - bcs_pkg::CORE_100K;
      nxt_s.osc = 1'b1;
    end
    else
      nxt_s.acc = sum;
    if (s_ff.osc)
    begin
      if (usSum >= f)
      begin
        nxt_s.usAcc = usSum - f; // [R24]
        nxt_s.us = 1'b1;
      end
      else
        nxt_s.usAcc = usSum;
      if (s_ff.divCnt >= period)
      begin
        nxt_s.divCnt = 8'h00;
        nxt_s.pwm = 1'b1; // [R20]
      end
      else
        nxt_s.divCnt = s_ff.divCnt + 8'h01;
    end
    nxt_s.valid = (divSel != 3'h0) && ({3'h0, f} >= 12'(bcs_pkg::DIV_STEP *
      bcs_pkg::MIN_RATE_100K) * (12'(divSel) + 12'h001)); // [R22]
    if (sys_rst)
      nxt_s = '0;
  end

  always_ff @(posedge core_clk)
    s_ff <= nxt_s;

  assign usTick = s_ff.us;
  assign pwmTick = s_ff.pwm;
  assign rateValid = s_ff.valid;
endmodule : bcs_timebase
`default_nettype wire

/* File: rtl/bcs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_sequencer
#(
  parameter int OC_RESTART_US = bcs_pkg::OC_RESTART_MS * bcs_pkg::US_PER_MS
)
(
  // Clock and synchronous reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter measurements on the core clock.
  input wire logic [3:0][9:0] outVoltMeas,
  input wire logic [3:0][8:0] curSenseMv,
  input wire logic [3:0] curSenseValid,
  // Power stage and indications.
  output logic [3:0][6:0] refCode,
  output logic [3:0] switchEn,
  output logic [3:0] lowGateForce,
  output logic [3:0] powerGood,
  output logic switchTick,
  output logic gpioIndicator
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [3:0] chEn;
    logic [15:0] follow;
    logic [7:0] swRate;
    logic [12:0] route;
    logic [3:0] ovFlag;
    logic [3:0] ocFlag;
    logic [3:0] ocWarn;
    logic [3:0][6:0] target;
    logic [3:0][1:0] ovSel;
    logic [3:0] ovStyle;
    logic [3:0][7:0] curLim;
    logic [3:0][15:0] rampUp;
    logic [3:0][15:0] rampDn;
    logic [3:0][7:0] pgLo;
    logic [3:0][7:0] pgHi;
    logic [3:0][5:0] pgDly;
    bcs_pkg::bcs_chst_t [3:0] st;
    logic [3:0][6:0] refLvl;
    logic [3:0][17:0] tmr;
    logic [3:0] pg;
    logic gpio;
  } bcs_state_t;

  bcs_state_t s_ff, nxt_s;
  logic usTick, pwmTick, rateValid;
  logic [3:0] ovTrip, ocTrip, ovLead, ocLead, reEn, warnNow;

  bcs_timebase u_timebase (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .oscSel(s_ff.swRate[6:4]),
    .divSel(s_ff.swRate[2:0]),
    .usTick(usTick),
    .pwmTick(pwmTick),
    .rateValid(rateValid)
  );

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] din,
    input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = din[8*b +: 8];
    return r;
  endfunction : mergeBytes

  function automatic logic [17:0] stepTime(input logic [5:0] steps);
    return 18'(steps) * 18'(bcs_pkg::DELAY_STEP_US);
  endfunction : stepTime

  // A zero step period would stall the ramp, so it runs as one microsecond.
  function automatic logic [17:0] rampPeriod(input logic [9:0] n);
    return (n == 10'h000) ? 18'h00001 : 18'(n);
  endfunction : rampPeriod

  function automatic logic isSwitching(input bcs_pkg::bcs_chst_t st);
    return st == bcs_pkg::CH_RAMPUP || st == bcs_pkg::CH_ON ||
      st == bcs_pkg::CH_DLYDN || st == bcs_pkg::CH_RAMPDN;
  endfunction : isSwitching

  // Trip level in 10mV units: nominal plus the selected offset, doubled on high targets.
  function automatic logic [10:0] ovLimit(input logic [6:0] tgt, input logic [1:0] sel);
    logic [10:0] off;
    off = 11'(bcs_pkg::OV_MIN_MV / bcs_pkg::MEAS_UNIT_MV) +
      11'(sel) * 11'(bcs_pkg::OV_STEP_MV / bcs_pkg::MEAS_UNIT_MV); // [R04]
    if (tgt > bcs_pkg::TARGET_HIGH_CODE)
      off = off << 1;
    return 11'(tgt) * 11'(bcs_pkg::TARGET_CODE_SCALE) + off; // [R01]
  endfunction : ovLimit

  always_comb
  begin
    logic wr;
    logic [1:0] ch;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [3:0] ovClr, ocClr;
    logic [8:0] limMv, warnOff, warnThr;
    logic inWin;
    nxt_s = s_ff;
    wr = 1'b0;
    ch = wb_adr_i[6:5];
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    ovClr = 4'h0;
    ocClr = 4'h0;
    limMv = 9'h000;
    warnOff = 9'h000;
    warnThr = 9'h000;
    inWin = 1'b0;
    ovTrip = 4'h0;
    ocTrip = 4'h0;
    ovLead = 4'h0;
    ocLead = 4'h0;
    reEn = 4'h0;
    warnNow = 4'h0;

    // The answer comes one cycle after the request and drops the cycle after.
    nxt_s.ack = wb_cyc_i && wb_stb_i && !s_ff.ack;
    wr = nxt_s.ack && wb_we_i;
    if (!wb_adr_i[7])
    begin
      unique case (wb_adr_i[4:2])
        bcs_pkg::W_TARGET:
        begin
          rd[6:0] = s_ff.target[ch];
          rd[bcs_pkg::FLD_OVSEL +: 2] = s_ff.ovSel[ch];
          rd[bcs_pkg::FLD_STYLE] = s_ff.ovStyle[ch];
        end
        bcs_pkg::W_CURLIM: rd[7:0] = s_ff.curLim[ch];
        bcs_pkg::W_RAMPUP: rd[15:0] = s_ff.rampUp[ch];
        bcs_pkg::W_RAMPDN: rd[15:0] = s_ff.rampDn[ch];
        bcs_pkg::W_PGWIN: rd[15:0] = {s_ff.pgHi[ch], s_ff.pgLo[ch]};
        bcs_pkg::W_PGDLY: rd[5:0] = s_ff.pgDly[ch];
        bcs_pkg::W_CHSTAT:
        begin
          rd[6:0] = s_ff.refLvl[ch];
          rd[bcs_pkg::FLD_STATE +: 3] = s_ff.st[ch];
          rd[bcs_pkg::FLD_PG] = s_ff.pg[ch];
        end
        default: rd = 32'h0000_0000;
      endcase
    end
    else
    begin
      unique case (wb_adr_i)
        bcs_pkg::A_CHEN: rd[3:0] = s_ff.chEn;
        bcs_pkg::A_FOLLOW_LO: rd[7:0] = s_ff.follow[7:0];
        bcs_pkg::A_FOLLOW_HI: rd[7:0] = s_ff.follow[15:8];
        bcs_pkg::A_SWRATE: rd[7:0] = s_ff.swRate;
        bcs_pkg::A_PROT: rd[3:0] = s_ff.ovFlag;
        bcs_pkg::A_OCFAULT: rd[3:0] = s_ff.ocFlag;
        bcs_pkg::A_OCWARN: rd[3:0] = s_ff.ocWarn;
        bcs_pkg::A_ROUTE: rd[12:0] = s_ff.route;
        default: rd = 32'h0000_0000;
      endcase
    end
    if (nxt_s.ack)
      nxt_s.rdat = rd;
    wv = mergeBytes(rd, wb_dat_i, wb_sel_i);

    if (wr && !wb_adr_i[7])
    begin
      unique case (wb_adr_i[4:2])
        bcs_pkg::W_TARGET:
        begin
          nxt_s.target[ch] = wv[6:0];
          nxt_s.ovSel[ch] = wv[bcs_pkg::FLD_OVSEL +: 2];
          nxt_s.ovStyle[ch] = wv[bcs_pkg::FLD_STYLE];
        end
        bcs_pkg::W_CURLIM: nxt_s.curLim[ch] = wv[7:0];
        bcs_pkg::W_RAMPUP: nxt_s.rampUp[ch] = wv[15:0];
        bcs_pkg::W_RAMPDN: nxt_s.rampDn[ch] = wv[15:0];
        bcs_pkg::W_PGWIN:
        begin
          nxt_s.pgLo[ch] = wv[7:0];
          nxt_s.pgHi[ch] = wv[bcs_pkg::FLD_PGHI +: 8];
        end
        bcs_pkg::W_PGDLY: nxt_s.pgDly[ch] = wv[5:0];
        default: nxt_s.target[ch] = s_ff.target[ch];
      endcase
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        bcs_pkg::A_CHEN:
        begin
          nxt_s.chEn = wv[3:0];
          reEn = wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0; // [R06]
        end
        bcs_pkg::A_FOLLOW_LO: nxt_s.follow[7:0] = wv[7:0];
        bcs_pkg::A_FOLLOW_HI: nxt_s.follow[15:8] = wv[7:0];
        bcs_pkg::A_SWRATE: nxt_s.swRate = wv[7:0];
        bcs_pkg::A_PROT: ovClr = wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0;
        bcs_pkg::A_OCFAULT: ocClr = wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0;
        bcs_pkg::A_ROUTE: nxt_s.route = wv[12:0];
        default: nxt_s.route = s_ff.route;
      endcase
    end

    // Detection: over-voltage is watched in every state but the latched one.
    for (int c = 0; c < 4; c++)
    begin
      ovTrip[c] = ({1'b0, outVoltMeas[c]} > ovLimit(s_ff.target[c], s_ff.ovSel[c])) &&
        s_ff.st[c] != bcs_pkg::CH_OVHOLD; // [R02]
      limMv = 9'(s_ff.curLim[c][5:0]) * 9'(bcs_pkg::LIM_STEP_MV); // [R10]
      warnOff = 9'(bcs_pkg::WARN_MIN_MV) +
        9'(s_ff.curLim[c][7:6]) * 9'(bcs_pkg::WARN_STEP_MV); // [R11] [R23]
      warnThr = (limMv > warnOff) ? limMv - warnOff : 9'h000;
      warnNow[c] = curSenseMv[c] >= warnThr;
      ocTrip[c] = curSenseValid[c] && isSwitching(s_ff.st[c]) &&
        curSenseMv[c] >= limMv; // [R09]
      if (curSenseValid[c])
        nxt_s.ocWarn[c] = warnNow[c]; // [R12]
    end
    for (int c = 0; c < 4; c++)
      for (int f = 0; f < 4; f++)
        if (f != c && s_ff.follow[4*f + c])
        begin
          ovLead[c] = ovLead[c] | ovTrip[f]; // [R05]
          ocLead[c] = ocLead[c] | ocTrip[f]; // [R14]
        end

    // A new event outranks a clear written in the same cycle.
    nxt_s.ovFlag = (s_ff.ovFlag & ~ovClr) | ovTrip; // [R03]
    nxt_s.ocFlag = (s_ff.ocFlag & ~ocClr) | ocTrip; // [R14]

    for (int c = 0; c < 4; c++)
    begin
      inWin = {1'b0, outVoltMeas[c]} >= 11'(s_ff.pgLo[c]) * 11'(bcs_pkg::PG_STEP_MV /
        bcs_pkg::MEAS_UNIT_MV) && {1'b0, outVoltMeas[c]} <= 11'(s_ff.pgHi[c]) *
        11'(bcs_pkg::PG_STEP_MV / bcs_pkg::MEAS_UNIT_MV); // [R18]
      if (ovTrip[c] || ovLead[c])
      begin
        nxt_s.st[c] = bcs_pkg::CH_OVHOLD; // [R03] [R05]
        nxt_s.refLvl[c] = 7'h00;
        nxt_s.tmr[c] = 18'h00000;
        nxt_s.pg[c] = 1'b0;
      end
      else if (ocTrip[c] || (ocLead[c] && isSwitching(s_ff.st[c])))
      begin
        nxt_s.st[c] = bcs_pkg::CH_OCWAIT; // [R13] [R14]
        nxt_s.refLvl[c] = 7'h00;
        nxt_s.tmr[c] = 18'h00000;
        nxt_s.pg[c] = 1'b0;
      end
      else
      begin
        unique case (s_ff.st[c])
          bcs_pkg::CH_OFF:
            if (s_ff.chEn[c])
            begin
              nxt_s.st[c] = bcs_pkg::CH_DLYUP;
              nxt_s.tmr[c] = 18'h00000;
              nxt_s.refLvl[c] = 7'h00;
            end
          bcs_pkg::CH_DLYUP:
            if (!s_ff.chEn[c])
              nxt_s.st[c] = bcs_pkg::CH_OFF;
            else if (s_ff.tmr[c] >= stepTime(s_ff.rampUp[c][15:10]))
            begin
              nxt_s.st[c] = bcs_pkg::CH_RAMPUP; // [R15]
              nxt_s.tmr[c] = 18'h00000;
            end
            else if (usTick)
              nxt_s.tmr[c] = s_ff.tmr[c] + 18'h00001; // [R24]
          bcs_pkg::CH_RAMPUP:
            if (!s_ff.chEn[c])
            begin
              nxt_s.st[c] = bcs_pkg::CH_DLYDN;
              nxt_s.tmr[c] = 18'h00000;
            end
            else if (s_ff.refLvl[c] >= s_ff.target[c])
            begin
              nxt_s.st[c] = bcs_pkg::CH_ON;
              nxt_s.tmr[c] = 18'h00000;
            end
            else if (usTick)
            begin
              if (s_ff.tmr[c] + 18'h00001 >= rampPeriod(s_ff.rampUp[c][9:0]))
              begin
                nxt_s.refLvl[c] = s_ff.refLvl[c] + 7'h01; // [R16]
                nxt_s.tmr[c] = 18'h00000;
              end
              else
                nxt_s.tmr[c] = s_ff.tmr[c] + 18'h00001;
            end
          bcs_pkg::CH_ON:
          begin
            nxt_s.refLvl[c] = s_ff.target[c]; // [R01]
            if (!s_ff.chEn[c])
            begin
              nxt_s.st[c] = bcs_pkg::CH_DLYDN;
              nxt_s.tmr[c] = 18'h00000;
              nxt_s.pg[c] = 1'b0;
            end
            else if (inWin)
            begin
              if (s_ff.tmr[c] >= stepTime(s_ff.pgDly[c]))
                nxt_s.pg[c] = 1'b1; // [R18] [R19]
              else if (usTick)
                nxt_s.tmr[c] = s_ff.tmr[c] + 18'h00001;
            end
            else
            begin
              nxt_s.pg[c] = 1'b0;
              nxt_s.tmr[c] = 18'h00000;
            end
          end
          bcs_pkg::CH_DLYDN:
            if (s_ff.chEn[c])
              nxt_s.st[c] = bcs_pkg::CH_RAMPUP;
            else if (s_ff.tmr[c] >= stepTime(s_ff.rampDn[c][15:10]))
            begin
              nxt_s.st[c] = bcs_pkg::CH_RAMPDN; // [R17]
              nxt_s.tmr[c] = 18'h00000;
            end
            else if (usTick)
              nxt_s.tmr[c] = s_ff.tmr[c] + 18'h00001;
          bcs_pkg::CH_RAMPDN:
            if (s_ff.chEn[c])
              nxt_s.st[c] = bcs_pkg::CH_RAMPUP;
            else if (s_ff.refLvl[c] <= bcs_pkg::DISCHARGE_CODE)
              nxt_s.st[c] = bcs_pkg::CH_OFF;
            else if (usTick)
            begin
              if (s_ff.tmr[c] + 18'h00001 >= rampPeriod(s_ff.rampDn[c][9:0]))
              begin
                nxt_s.refLvl[c] = s_ff.refLvl[c] - 7'h01; // [R17]
                nxt_s.tmr[c] = 18'h00000;
              end
              else
                nxt_s.tmr[c] = s_ff.tmr[c] + 18'h00001;
            end
          bcs_pkg::CH_OVHOLD:
            if (reEn[c])
            begin
              nxt_s.st[c] = bcs_pkg::CH_DLYUP; // [R06]
              nxt_s.tmr[c] = 18'h00000;
            end
          bcs_pkg::CH_OCWAIT:
            if (s_ff.tmr[c] >= 18'(OC_RESTART_US))
            begin
              nxt_s.st[c] = s_ff.chEn[c] ? bcs_pkg::CH_DLYUP : bcs_pkg::CH_OFF; // [R13]
              nxt_s.tmr[c] = 18'h00000;
            end
            else if (usTick)
              nxt_s.tmr[c] = s_ff.tmr[c] + 18'h00001;
        endcase
      end
    end

    nxt_s.gpio = |(s_ff.route & {!rateValid, s_ff.ocWarn, s_ff.ocFlag, s_ff.ovFlag}); // [R07]

    if (sys_rst)
    begin
      nxt_s = '0;
      nxt_s.curLim = {4{bcs_pkg::RST_CURLIM}};
      nxt_s.rampUp = {4{bcs_pkg::RST_RAMP}};
      nxt_s.rampDn = {4{bcs_pkg::RST_RAMP}};
      nxt_s.swRate = bcs_pkg::RST_SWRATE;
    end
  end

  always_ff @(posedge core_clk)
    s_ff <= nxt_s;

  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.rdat;
  assign refCode = s_ff.refLvl;
  assign powerGood = s_ff.pg;
  assign gpioIndicator = s_ff.gpio;
  assign switchTick = pwmTick && rateValid;

  // Forced low keeps the low-side gate on until a host re-enable clears the hold.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_drive
      assign switchEn[g] = isSwitching(s_ff.st[g]) && rateValid;
      assign lowGateForce[g] = s_ff.st[g] == bcs_pkg::CH_OVHOLD && s_ff.ovStyle[g]; // [R08]
    end
  endgenerate

  a_wb_ack_once: assert property (@(posedge core_clk) disable iff (sys_rst)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone answer not a single pulse one cycle after request.");
  a_ov_shutdown: assert property (@(posedge core_clk) disable iff (sys_rst) // [R03]
    ovTrip[0] |=> s_ff.st[0] == bcs_pkg::CH_OVHOLD && !switchEn[0] && s_ff.ovFlag[0])
    else $error("Over-voltage did not shut channel 0 and flag it.");
  a_ov_follower: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
    ovTrip[0] && s_ff.follow[1] |=> s_ff.st[1] == bcs_pkg::CH_OVHOLD)
    else $error("Follower channel 1 not disabled with its leader.");
  a_ov_hold_latch: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
    s_ff.st[0] == bcs_pkg::CH_OVHOLD && !reEn[0] |=> s_ff.st[0] == bcs_pkg::CH_OVHOLD)
    else $error("Channel 0 left over-voltage hold without host re-enable.");
  a_forced_low: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
    lowGateForce[0] |-> s_ff.ovStyle[0] && s_ff.st[0] == bcs_pkg::CH_OVHOLD && !switchEn[0])
    else $error("Low-side gate forced outside a forced over-voltage hold.");
  a_warn_clear: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    curSenseValid[0] |=> s_ff.ocWarn[0] == $past(warnNow[0]))
    else $error("Over-current warning does not follow the sample.");
  a_oc_restart: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
    ocTrip[0] && !ovTrip[0] && !ovLead[0] |=> !switchEn[0] && s_ff.ocFlag[0] &&
    s_ff.st[0] == bcs_pkg::CH_OCWAIT)
    else $error("Over-current did not stop channel 0 and start the restart wait.");
  a_ramp_hold: assert property (@(posedge core_clk) disable iff (sys_rst) // [R16]
    s_ff.st[0] == bcs_pkg::CH_RAMPUP && !usTick && !ovTrip[0] && !ocTrip[0] && !ovLead[0] &&
    !ocLead[0] |=> $stable(refCode[0]))
    else $error("Reference moved between microsecond ticks.");
  a_pg_after_ss: assert property (@(posedge core_clk) disable iff (sys_rst) // [R19]
    powerGood[0] |-> s_ff.st[0] == bcs_pkg::CH_ON && $past(s_ff.st[0]) == bcs_pkg::CH_ON)
    else $error("Power-good asserted before soft-start finished.");
endmodule : bcs_sequencer
`default_nettype wire

/* File: verif/bcs_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_stage_model
(
  // Clock.
  input wire logic core_clk,
  // Drive from the sequencer.
  input wire logic [3:0][6:0] refCode,
  input wire logic [3:0] switchEn,
  input wire logic [3:0] lowGateForce,
  // Faults forced onto channel 0.
  input wire logic ovInj,
  input wire logic ocInj,
  // Measurements.
  output logic [3:0][9:0] outVoltMeas,
  output logic [3:0][8:0] curSenseMv,
  output logic [3:0] curSenseValid
);
  logic [3:0] phase;
  initial
  begin
    phase = 4'h0;
    outVoltMeas = '0;
    curSenseMv = '0;
    curSenseValid = 4'h0;
  end
  always @(posedge core_clk)
  begin
    phase <= phase + 4'h1;
    for (int c = 0; c < 4; c++)
    begin
      // A held low-side gate discharges the output.
      outVoltMeas[c] <= ((switchEn[c] && !lowGateForce[c]) ? 10'(refCode[c] * 5) : 10'h000)
        + ((ovInj && c == 0) ? 10'h014 : 10'h000);
      curSenseValid[c] <= (phase == 4'h0);
      // Between samples the sense line carries no stable value.
      curSenseMv[c] <= (phase != 4'h0) ? {5'h00, ~phase} :
        ((ocInj && c == 0 && switchEn[c]) ? 9'h1ff : 9'h020);
    end
  end
endmodule : bcs_stage_model
`default_nettype wire

/* File: verif/bcs_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic ovInj = 1'b0;
  logic ocInj = 1'b0;
  logic [31:0] wb_dat_o, rdat;
  logic wb_ack_o, switchTick, gpioIndicator;
  logic [3:0][9:0] outVoltMeas;
  logic [3:0][8:0] curSenseMv;
  logic [3:0] curSenseValid, switchEn, lowGateForce, powerGood;
  logic [3:0][6:0] refCode;
  logic [6:0] tgt;
  logic [31:0] expQ[$];
  int miscompares = 0;
  int check_count = 0;
  int ticks = 0;
  always #2.5 core_clk = ~core_clk;
  bcs_sequencer #(.OC_RESTART_US(20)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .outVoltMeas(outVoltMeas), .curSenseMv(curSenseMv), .curSenseValid(curSenseValid),
    .refCode(refCode), .switchEn(switchEn), .lowGateForce(lowGateForce),
    .powerGood(powerGood), .switchTick(switchTick), .gpioIndicator(gpioIndicator));
  bcs_stage_model i_stage (.core_clk(core_clk), .refCode(refCode), .switchEn(switchEn),
    .lowGateForce(lowGateForce), .ovInj(ovInj), .ocInj(ocInj), .outVoltMeas(outVoltMeas),
    .curSenseMv(curSenseMv), .curSenseValid(curSenseValid));
  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read results are judged here, oldest expectation first.
  always @(posedge core_clk)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0)
      chk(wb_dat_o, expQ.pop_front());
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask : rd
  task automatic waitState(input logic [2:0] st);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 8'h18, 32'h0);
      n++;
    end
    while (rdat[9:7] !== st && n < 6000);
    chk({29'h0, rdat[9:7]}, {29'h0, st});
    if (rdat[9:7] !== st)
      wrap_up();
  endtask : waitState
  // A short window sees a few switching pulses whatever their phase.
  task automatic countTicks();
    ticks = 0;
    repeat (400)
    begin
      @(posedge core_clk);
      if (switchTick === 1'b1)
        ticks++;
    end
  endtask : countTicks
  initial
  begin
    void'($urandom(20));
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(8'h04, 32'h3f);
    rd(8'h08, 32'h0414);
    rd(8'h8c, 32'h01);
    rd(8'ha0, 32'h0);
    tgt = 7'($urandom_range(2, 50));
    bus(1'b1, 8'h00, {19'h0, 1'b1, 5'h00, tgt});
    rd(8'h00, {19'h0, 1'b1, 5'h00, tgt});
    bus(1'b1, 8'h08, 32'h0001);
    bus(1'b1, 8'h80, 32'h1);
    waitState(3'h3);
    chk({25'h0, refCode[0]}, {25'h0, tgt});
    bus(1'b1, 8'h10, 32'hff00);
    rd(8'h18, {21'h0, 1'b1, 3'h3, tgt});
    chk({31'h0, powerGood[0]}, 32'h1);
    countTicks();
    chk({31'h0, ticks >= 2 && ticks <= 4}, 32'h1);
    bus(1'b1, 8'h9c, 32'h1000);
    bus(1'b1, 8'h8c, 32'h00);
    countTicks();
    chk(ticks, 32'h0);
    chk({31'h0, switchEn[0]}, 32'h0);
    chk({31'h0, gpioIndicator}, 32'h1);
    bus(1'b1, 8'h8c, 32'h01);
    bus(1'b1, 8'h84, 32'h02);
    ovInj <= 1'b1;
    waitState(3'h6);
    ovInj <= 1'b0;
    chk({31'h0, switchEn[0]}, 32'h0);
    chk({31'h0, lowGateForce[0]}, 32'h1);
    rd(8'h90, 32'h1);
    rd(8'h38, 32'h300);
    repeat (600) @(posedge core_clk);
    waitState(3'h6);
    bus(1'b1, 8'h90, 32'h1);
    bus(1'b1, 8'h80, 32'h1);
    waitState(3'h3);
    ocInj <= 1'b1;
    waitState(3'h7);
    ocInj <= 1'b0;
    rd(8'h94, 32'h1);
    waitState(3'h3);
    rd(8'h98, 32'h0);
    wrap_up();
  end
endmodule : bcs_sequencer_tb_top
`default_nettype wire
